// ===== pkg/nmea_framer_defs.svh
`ifndef NMEA_FRAMER_DEFS_SVH
`define NMEA_FRAMER_DEFS_SVH

// serial character format
`define CLK_HZ 40000000
`define BAUD_RATE 115200
`define BAUD_CYCLES ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define DATA_BITS 8
`define STOP_BITS 1
`define PARITY_EN 0

// periodic report interval
`define REPORT_PERIOD_MS 1000
`define REPORT_CYCLES (`CLK_HZ / 1000 * `REPORT_PERIOD_MS)

// sentence length limits
`define MAX_SENTENCE 79
`define MAX_BLOCK 74
`define ADDR_CHARS 5
`define TAIL_CHARS 3

// framing characters
`define CH_DOLLAR 8'h24
`define CH_STAR 8'h2a
`define CH_COMMA 8'h2c
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_DOT 8'h2e
`define CH_MINUS 8'h2d
`define CH_G 8'h47
`define CH_P 8'h50
`define CH_L 8'h4c
`define CH_A 8'h41
`define CH_V 8'h56

`endif

// ===== pkg/nmea_framer_pkg.sv
package nmea_framer_pkg;
	typedef logic [7:0] char_t;

	// content class of a loaded field character
	typedef enum logic [2:0] {
		FC_FREE,
		FC_STATUS,
		FC_DIGIT,
		FC_NUMERIC,
		FC_HEX,
		FC_ALPHA
	} field_class_t;

	// one character of the outgoing data field block
	typedef struct packed {
		logic valid;
		logic first;
		field_class_t cls;
		char_t data;
	} load_t;

	// one received field character
	typedef struct packed {
		logic valid;
		logic [6:0] index;
		char_t data;
	} rx_field_t;

	// address field of a received sentence
	typedef struct packed {
		logic [1:0][7:0] source_tag;
		logic [2:0][7:0] sentence_type_code;
	} rx_hdr_t;
endpackage

// ===== hdl/field_mem.sv
`timescale 1ns/10ps
`default_nettype none

// field block store with registered read data
module field_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 74,
	parameter int AW = $clog2(DEPTH)
) (
	// clock
	input wire logic i_sys_clk,
	// write port
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	// read port
	input wire logic [AW-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// write and registered read
	always_ff @(posedge i_sys_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end
endmodule

`default_nettype wire

// ===== hdl/nmea_sentence_framer.sv
// What this block does
// - characters are 115 kbps, 8 data bits, no parity, 1 stop bit.
// - the block is the only talker driving its transmit byte stream.
// - every sentence starts with dollar; a received dollar restarts parsing.
// - two source letters follow dollar: GP for GPS or agnostic, GL for GLONASS.
// - three sentence type letters follow the source letters.
// - fields are comma separated; received fields are indexed by comma count.
// - after the fields comes an asterisk and two hex checksum characters.
// - every sentence ends with CR then LF; receive end is detected on it.
// - at most 79 characters excluding dollar and CR LF; longer is malformed.
// - the data field block with commas holds at most 74 characters.
// - a status field is one character, A valid or V invalid.
// - latitude uses two degree and two minute digits, optional fraction.
// - longitude uses three degree and two minute digits, optional fraction.
// - time uses two digit hours, minutes, seconds, optional fraction.
// - variable numbers may be integer or fractional with optional zeros.
// - fixed hex fields hold only hex digits, most significant first.
// - fixed alpha fields take letters of either case; receiver accepts both.
// - fixed numeric fields hold only digit characters; the digit class also takes dot, the numeric class dot and minus.
// - with output enabled a report tick fires once every second.
// - the block both sends sentences and accepts input sentences.
`timescale 1ns/10ps
`default_nettype none
`include "nmea_framer_defs.svh"

module nmea_sentence_framer #(
	parameter int BLOCK_DEPTH = `MAX_BLOCK,
	parameter int unsigned SECOND_CYCLES = `REPORT_CYCLES
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// field block load
	input wire nmea_framer_pkg::load_t i_load,
	output logic o_load_ready,
	output logic o_load_err,
	// sentence send request
	input wire logic i_send,
	input wire logic i_glonass,
	input wire logic [2:0][7:0] i_sentence_type_code,
	// transmit bytes to the character engine
	output logic o_tx_valid,
	output nmea_framer_pkg::char_t o_tx_data,
	input wire logic i_tx_ready,
	// received bytes from the character engine
	input wire logic i_rx_valid,
	input wire nmea_framer_pkg::char_t i_rx_data,
	// receive results
	output nmea_framer_pkg::rx_field_t o_rx_field,
	output nmea_framer_pkg::rx_hdr_t o_rx_hdr,
	output logic o_rx_done,
	output logic o_rx_err,
	// rate ticks
	input wire logic i_output_en,
	output logic o_baud_tick,
	output logic o_second_tick
);
	import nmea_framer_pkg::*;

	localparam int AW = $clog2(BLOCK_DEPTH);
	localparam int LIM_A = `MAX_BLOCK - 1;
	localparam int LIM_B = `MAX_SENTENCE - `ADDR_CHARS - `TAIL_CHARS - 1;
	localparam logic [6:0] STORE_MAX = 7'((LIM_A < LIM_B) ? LIM_A : LIM_B);
	localparam logic [6:0] SENT_MAX = 7'(`MAX_SENTENCE);
	localparam logic [8:0] BAUD_LAST = 9'(`BAUD_CYCLES - 1);
	localparam logic [25:0] SEC_LAST = 26'(SECOND_CYCLES - 1);

	typedef enum {T_IDLE, T_DOLLAR, T_SRC, T_TYPE, T_COMMA, T_FETCH, T_FIELD,
		T_STAR, T_CKH, T_CKL, T_CR, T_LF} tx_state_t;
	typedef enum {R_HUNT, R_BODY, R_CK1, R_CK2, R_CR, R_LF} rx_state_t;

	// uppercase hex character of a nibble
	function automatic char_t hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// hex digit of either case
	function automatic logic is_hex(input char_t c);
		is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
	endfunction

	function automatic logic [3:0] hex_val(input char_t c);
		if (c <= 8'h39) begin
			hex_val = c[3:0];
		end else begin
			hex_val = c[3:0] + 4'h9;
		end
	endfunction

	// character allowed in a field of the given class
	function automatic logic class_ok(input field_class_t cls, input char_t c);
		logic dig;
		dig = (c >= 8'h30 && c <= 8'h39);
		case (cls)
			FC_STATUS: class_ok = (c == `CH_A) || (c == `CH_V);
			FC_DIGIT: class_ok = dig || (c == `CH_DOT);
			FC_NUMERIC: class_ok = dig || (c == `CH_DOT) || (c == `CH_MINUS);
			FC_HEX: class_ok = dig || (c >= 8'h41 && c <= 8'h46);
			FC_ALPHA: class_ok = (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
			default: class_ok = (c != `CH_DOLLAR) && (c != `CH_STAR) && (c != `CH_CR) && (c != `CH_LF);
		endcase
	endfunction

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	// ---- rate ticks
	logic [8:0] baud_cnt_ff, nxt_baud_cnt;
	logic [25:0] sec_cnt_ff, nxt_sec_cnt;
	logic nxt_baud_tick, nxt_second_tick;

	// bit rate enable and report interval tick
	always_comb begin
		nxt_baud_tick = (baud_cnt_ff == BAUD_LAST);
		nxt_baud_cnt = nxt_baud_tick ? 9'h000 : baud_cnt_ff + 9'h001;
		nxt_second_tick = i_output_en && (sec_cnt_ff == SEC_LAST);
		nxt_sec_cnt = (!i_output_en || nxt_second_tick) ? 26'h0000000 : sec_cnt_ff + 26'h0000001;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			baud_cnt_ff <= 9'h000;
			sec_cnt_ff <= 26'h0000000;
			o_baud_tick <= 1'b0;
			o_second_tick <= 1'b0;
		end else begin
			baud_cnt_ff <= nxt_baud_cnt;
			sec_cnt_ff <= nxt_sec_cnt;
			o_baud_tick <= nxt_baud_tick;
			o_second_tick <= nxt_second_tick;
		end
	end

	a_baud_spacing: assert property (o_baud_tick |=> !o_baud_tick [*8]) else $error("baud tick too close");
	a_second_spacing: assert property (o_second_tick |=> !o_second_tick [*2]) else $error("second tick repeats");

	// ---- transmit framer
	tx_state_t tx_state_ff, nxt_tx_state;
	logic [1:0] idx_ff, nxt_idx;
	logic [6:0] count_ff, nxt_count;
	logic [AW-1:0] rd_addr_ff, nxt_rd_addr;
	logic [7:0] ck_ff, nxt_ck;
	logic [1:0][7:0] src_ff, nxt_src;
	logic [2:0][7:0] type_ff, nxt_type;
	logic nxt_tx_valid, nxt_load_ready, nxt_load_err, wr_en, free;
	char_t nxt_tx_data, rd_data;
	logic [AW-1:0] wr_addr;

	field_mem #(.WIDTH(8), .DEPTH(BLOCK_DEPTH)) u_field_mem (
		.i_sys_clk(i_sys_clk),
		.i_wr_en(wr_en),
		.i_wr_addr(wr_addr),
		.i_wr_data(i_load.data),
		.i_rd_addr(rd_addr_ff),
		.o_rd_data(rd_data)
	);

	assign free = !o_tx_valid || i_tx_ready;
	assign wr_addr = i_load.first ? '0 : AW'(count_ff);

	// block load, sentence sequencing and checksum
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_idx = idx_ff;
		nxt_count = count_ff;
		nxt_rd_addr = rd_addr_ff;
		nxt_ck = ck_ff;
		nxt_src = src_ff;
		nxt_type = type_ff;
		nxt_tx_valid = o_tx_valid && !i_tx_ready;
		nxt_tx_data = o_tx_data;
		nxt_load_err = 1'b0;
		wr_en = 1'b0;
		if (o_load_ready && i_load.valid) begin
			if (!class_ok(i_load.cls, i_load.data) || (!i_load.first && count_ff >= STORE_MAX)) begin
				nxt_load_err = 1'b1;
			end else begin
				wr_en = 1'b1;
				nxt_count = i_load.first ? 7'h01 : count_ff + 7'h01;
			end
		end
		case (tx_state_ff)
			T_IDLE: begin
				if (i_send) begin
					nxt_src = {`CH_G, i_glonass ? `CH_L : `CH_P};
					nxt_type = i_sentence_type_code;
					nxt_tx_state = T_DOLLAR;
				end
			end
			T_DOLLAR: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = `CH_DOLLAR;
					nxt_ck = 8'h00;
					nxt_idx = 2'h1;
					nxt_tx_state = T_SRC;
				end
			end
			T_SRC: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = src_ff[idx_ff[0]];
					nxt_ck = ck_ff ^ src_ff[idx_ff[0]];
					nxt_idx = (idx_ff == 2'h0) ? 2'h2 : 2'h0;
					nxt_tx_state = (idx_ff == 2'h0) ? T_TYPE : T_SRC;
				end
			end
			T_TYPE: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = type_ff[idx_ff];
					nxt_ck = ck_ff ^ type_ff[idx_ff];
					nxt_idx = idx_ff - 2'h1;
					nxt_tx_state = (idx_ff == 2'h0) ? T_COMMA : T_TYPE;
				end
			end
			T_COMMA: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = `CH_COMMA;
					nxt_ck = ck_ff ^ `CH_COMMA;
					nxt_rd_addr = '0;
					nxt_tx_state = (count_ff == 7'h00) ? T_STAR : T_FETCH;
				end
			end
			T_FETCH: nxt_tx_state = T_FIELD;
			T_FIELD: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = rd_data;
					nxt_ck = ck_ff ^ rd_data;
					nxt_rd_addr = rd_addr_ff + 1'b1;
					nxt_tx_state = (7'(rd_addr_ff) + 7'h01 >= count_ff) ? T_STAR : T_FETCH;
				end
			end
			T_STAR: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = `CH_STAR;
					nxt_tx_state = T_CKH;
				end
			end
			T_CKH: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = hex_char(ck_ff[7:4]);
					nxt_tx_state = T_CKL;
				end
			end
			T_CKL: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = hex_char(ck_ff[3:0]);
					nxt_tx_state = T_CR;
				end
			end
			T_CR: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = `CH_CR;
					nxt_tx_state = T_LF;
				end
			end
			T_LF: begin
				if (free) begin
					nxt_tx_valid = 1'b1;
					nxt_tx_data = `CH_LF;
					nxt_tx_state = T_IDLE;
				end
			end
			default: nxt_tx_state = T_IDLE;
		endcase
		nxt_load_ready = (nxt_tx_state == T_IDLE);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tx_state_ff <= T_IDLE;
			idx_ff <= 2'h0;
			count_ff <= 7'h00;
			rd_addr_ff <= '0;
			ck_ff <= 8'h00;
			src_ff <= {`CH_G, `CH_P};
			type_ff <= '0;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
			o_load_ready <= 1'b1;
			o_load_err <= 1'b0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			idx_ff <= nxt_idx;
			count_ff <= nxt_count;
			rd_addr_ff <= nxt_rd_addr;
			ck_ff <= nxt_ck;
			src_ff <= nxt_src;
			type_ff <= nxt_type;
			o_tx_valid <= nxt_tx_valid;
			o_tx_data <= nxt_tx_data;
			o_load_ready <= nxt_load_ready;
			o_load_err <= nxt_load_err;
		end
	end

	sequence s_dollar_taken;
		o_tx_valid && i_tx_ready && o_tx_data == `CH_DOLLAR;
	endsequence
	sequence s_star_taken;
		o_tx_valid && i_tx_ready && o_tx_data == `CH_STAR;
	endsequence
	// first source letter handed over, second letter is due next
	sequence s_tag_g_taken;
		o_tx_valid && i_tx_ready && tx_state_ff == T_SRC && o_tx_data == `CH_G;
	endsequence

	a_dollar_start: assert property ((tx_state_ff == T_DOLLAR) && free |=> o_tx_valid && o_tx_data == `CH_DOLLAR)
		else $error("sentence did not open with dollar");
	a_source_tag: assert property (s_dollar_taken |=> o_tx_valid && o_tx_data == `CH_G)
		else $error("source tag does not open with G");
	a_source_second: assert property (s_tag_g_taken |=> o_tx_valid && (o_tx_data == `CH_P || o_tx_data == `CH_L))
		else $error("second source letter wrong");
	a_checksum_hex: assert property (s_star_taken |=> o_tx_valid && o_tx_data == hex_char(ck_ff[7:4]))
		else $error("checksum high digit wrong");
	a_crlf_pair: assert property (o_tx_valid && i_tx_ready && o_tx_data == `CH_CR |=> o_tx_valid && o_tx_data == `CH_LF)
		else $error("CR not followed by LF");
	a_block_limit: assert property (count_ff <= STORE_MAX) else $error("field block too long");
	a_load_check: assert property (o_load_ready && i_load.valid && !class_ok(i_load.cls, i_load.data) |=> o_load_err)
		else $error("bad field character accepted");

	// ---- receive checker
	rx_state_t rx_state_ff, nxt_rx_state;
	logic [6:0] rx_len_ff, nxt_rx_len, rx_comma_ff, nxt_rx_comma;
	logic [2:0] rx_pos_ff, nxt_rx_pos;
	logic [7:0] rx_ck_ff, nxt_rx_ck;
	logic [3:0] rx_hi_ff, nxt_rx_hi;
	logic rx_match_ff, nxt_rx_match, nxt_rx_done, nxt_rx_err;
	rx_field_t nxt_rx_field;
	rx_hdr_t nxt_rx_hdr;

	// parse received sentences
	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_len = rx_len_ff;
		nxt_rx_comma = rx_comma_ff;
		nxt_rx_pos = rx_pos_ff;
		nxt_rx_ck = rx_ck_ff;
		nxt_rx_hi = rx_hi_ff;
		nxt_rx_match = rx_match_ff;
		nxt_rx_hdr = o_rx_hdr;
		nxt_rx_field = '{valid: 1'b0, index: rx_comma_ff, data: i_rx_data};
		nxt_rx_done = 1'b0;
		nxt_rx_err = 1'b0;
		if (i_rx_valid) begin
			if (i_rx_data == `CH_DOLLAR) begin
				nxt_rx_err = (rx_state_ff != R_HUNT);
				nxt_rx_state = R_BODY;
				nxt_rx_len = 7'h00;
				nxt_rx_comma = 7'h00;
				nxt_rx_pos = 3'h0;
				nxt_rx_ck = 8'h00;
			end else if (rx_state_ff != R_HUNT && rx_state_ff != R_CR && rx_state_ff != R_LF
				&& rx_len_ff >= SENT_MAX) begin
				nxt_rx_err = 1'b1;
				nxt_rx_state = R_HUNT;
			end else begin
				case (rx_state_ff)
					R_BODY: begin
						nxt_rx_len = rx_len_ff + 7'h01;
						if (i_rx_data == `CH_STAR) begin
							nxt_rx_state = R_CK1;
						end else if (i_rx_data == `CH_CR || i_rx_data == `CH_LF) begin
							nxt_rx_err = 1'b1;
							nxt_rx_state = R_HUNT;
						end else begin
							nxt_rx_ck = rx_ck_ff ^ i_rx_data;
							if (i_rx_data == `CH_COMMA) begin
								nxt_rx_comma = rx_comma_ff + 7'h01;
							end else if (rx_comma_ff == 7'h00 && rx_pos_ff < 3'h5) begin
								nxt_rx_pos = rx_pos_ff + 3'h1;
								if (rx_pos_ff < 3'h2) begin
									nxt_rx_hdr.source_tag[3'h1 - rx_pos_ff] = i_rx_data;
								end else begin
									nxt_rx_hdr.sentence_type_code[3'h4 - rx_pos_ff] = i_rx_data;
								end
							end else begin
								nxt_rx_field.valid = 1'b1;
							end
						end
					end
					R_CK1: begin
						nxt_rx_len = rx_len_ff + 7'h01;
						nxt_rx_hi = hex_val(i_rx_data);
						nxt_rx_state = is_hex(i_rx_data) ? R_CK2 : R_HUNT;
						nxt_rx_err = !is_hex(i_rx_data);
					end
					R_CK2: begin
						nxt_rx_len = rx_len_ff + 7'h01;
						nxt_rx_match = ({rx_hi_ff, hex_val(i_rx_data)} == rx_ck_ff);
						nxt_rx_state = is_hex(i_rx_data) ? R_CR : R_HUNT;
						nxt_rx_err = !is_hex(i_rx_data);
					end
					R_CR: begin
						nxt_rx_state = (i_rx_data == `CH_CR) ? R_LF : R_HUNT;
						nxt_rx_err = (i_rx_data != `CH_CR);
					end
					R_LF: begin
						nxt_rx_state = R_HUNT;
						nxt_rx_done = (i_rx_data == `CH_LF) && rx_match_ff && (rx_pos_ff == 3'h5);
						nxt_rx_err = !nxt_rx_done;
					end
					default: nxt_rx_state = R_HUNT;
				endcase
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rx_state_ff <= R_HUNT;
			rx_len_ff <= 7'h00;
			rx_comma_ff <= 7'h00;
			rx_pos_ff <= 3'h0;
			rx_ck_ff <= 8'h00;
			rx_hi_ff <= 4'h0;
			rx_match_ff <= 1'b0;
			o_rx_field <= '0;
			o_rx_hdr <= '0;
			o_rx_done <= 1'b0;
			o_rx_err <= 1'b0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rx_len_ff <= nxt_rx_len;
			rx_comma_ff <= nxt_rx_comma;
			rx_pos_ff <= nxt_rx_pos;
			rx_ck_ff <= nxt_rx_ck;
			rx_hi_ff <= nxt_rx_hi;
			rx_match_ff <= nxt_rx_match;
			o_rx_field <= nxt_rx_field;
			o_rx_hdr <= nxt_rx_hdr;
			o_rx_done <= nxt_rx_done;
			o_rx_err <= nxt_rx_err;
		end
	end

	a_rx_restart: assert property (i_rx_valid && i_rx_data == `CH_DOLLAR |=> rx_state_ff == R_BODY && rx_len_ff == 7'h00)
		else $error("dollar did not restart parse");
	a_rx_length: assert property (rx_len_ff <= SENT_MAX) else $error("receive length past limit");
	a_rx_comma: assert property (i_rx_valid && rx_state_ff == R_BODY && i_rx_data == `CH_COMMA && rx_len_ff < SENT_MAX
		|=> rx_comma_ff == $past(rx_comma_ff) + 7'h01) else $error("comma not counted");
	a_rx_bad_ck: assert property (i_rx_valid && rx_state_ff == R_LF && !rx_match_ff |=> o_rx_err && !o_rx_done)
		else $error("bad checksum accepted");
endmodule

`default_nettype wire

// ===== verif/char_engine_model.sv
`timescale 1ns/10ps
`default_nettype none

// character engine on the far side: stalling byte sink, strobed byte source
module char_engine_model (
	// clock
	input wire logic i_sys_clk,
	// stall control
	input wire logic i_stall_en,
	// transmit handshake
	output logic o_tx_ready,
	// received byte stream
	output logic o_rx_valid,
	output nmea_framer_pkg::char_t o_rx_data
);
	import nmea_framer_pkg::*;

	// quiet lines at time zero
	initial begin
		o_tx_ready = 1'b1;
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
	end

	// ready stalls at random, moved off the sampling edge
	always @(negedge i_sys_clk) begin
		o_tx_ready <= i_stall_en ? ($urandom_range(3) != 0) : 1'b1;
	end

	// one whole 8-bit character per strobe, random idle gaps between them
	task automatic feed(input char_t q[$]);
		foreach (q[i]) begin
			@(negedge i_sys_clk);
			o_rx_valid <= 1'b1;
			o_rx_data <= q[i];
			@(negedge i_sys_clk);
			o_rx_valid <= 1'b0;
			o_rx_data <= ~q[i]; // stale data never mirrors the last byte
			repeat ($urandom_range(2)) @(negedge i_sys_clk);
		end
	endtask
endmodule

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "nmea_framer_defs.svh"

module tb;
	import nmea_framer_pkg::*;
	localparam int unsigned SEC = 20;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	load_t i_load = '0;
	logic i_send = 1'b0;
	logic i_glonass = 1'b0;
	logic [2:0][7:0] i_sentence_type_code = '0;
	logic i_output_en = 1'b0;
	logic stall_en = 1'b0;
	logic o_load_ready, o_load_err, o_tx_valid, tx_ready, rx_valid;
	logic o_rx_done, o_rx_err, o_baud_tick, o_second_tick;
	char_t o_tx_data, rx_data;
	rx_field_t o_rx_field;
	rx_hdr_t o_rx_hdr;
	char_t txq[$], expq[$], blk[$];
	logic [14:0] rxq[$], rexp[$];
	int err_total = 0, compares = 0, cyc = 0, done_cnt = 0, rerr_cnt = 0, sec_cnt = 0;
	int last_baud = -1, last_sec = -1, baud_gap = 0, sec_gap = 0;

	nmea_sentence_framer #(.BLOCK_DEPTH(`MAX_BLOCK), .SECOND_CYCLES(SEC)) nmea_sentence_framer_i (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_load(i_load), .o_load_ready(o_load_ready),
		.o_load_err(o_load_err), .i_send(i_send), .i_glonass(i_glonass),
		.i_sentence_type_code(i_sentence_type_code), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
		.i_tx_ready(tx_ready), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_field(o_rx_field),
		.o_rx_hdr(o_rx_hdr), .o_rx_done(o_rx_done), .o_rx_err(o_rx_err), .i_output_en(i_output_en),
		.o_baud_tick(o_baud_tick), .o_second_tick(o_second_tick));
	char_engine_model char_engine_model_i (.i_sys_clk(i_sys_clk), .i_stall_en(stall_en),
		.o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));

	always #12.5 i_sys_clk = ~i_sys_clk;

	// monitors: taken tx bytes, rx results and tick spacing
	always @(posedge i_sys_clk) begin
		cyc++;
		if (o_tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(o_tx_data);
		if (o_rx_field.valid === 1'b1 && o_rx_field.data !== `CH_COMMA) rxq.push_back({o_rx_field.index, o_rx_field.data});
		if (o_rx_done === 1'b1) done_cnt++;
		if (o_rx_err === 1'b1) rerr_cnt++;
		if (o_baud_tick === 1'b1) begin
			if (last_baud >= 0) baud_gap = cyc - last_baud;
			last_baud = cyc;
		end
		if (o_second_tick === 1'b1) begin
			if (last_sec >= 0) sec_gap = cyc - last_sec;
			last_sec = cyc;
			sec_cnt++;
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic char_t hexc(input logic [3:0] n, input logic low);
		return (n < 4'ha) ? 8'h30 + n : (low ? 8'h57 : 8'h37) + n;
	endfunction

	function automatic string digits(input int n);
		string s;
		s = "";
		for (int i = 0; i < n; i++) s = {s, "0"};
		for (int i = 0; i < n; i++) s.putc(i, byte'(8'h30 + $urandom_range(9)));
		return s;
	endfunction

	// one field character strobe, refusal seen in either of the two following cycles
	task automatic load_char(input field_class_t c, input char_t d, input logic f, input logic bad);
		logic e;
		@(negedge i_sys_clk);
		i_load <= '{valid: 1'b1, first: f, cls: c, data: d};
		@(negedge i_sys_clk);
		i_load.valid <= 1'b0;
		e = o_load_err;
		@(negedge i_sys_clk);
		e = e | o_load_err;
		chk("load_err", e, bad);
	endtask

	// reference sentence built from the stored block, then compared byte for byte
	task automatic do_send(input logic gl, input string typ);
		char_t cs;
		int n;
		cs = 8'h00;
		expq = '{`CH_DOLLAR, `CH_G, gl ? `CH_L : `CH_P, typ[0], typ[1], typ[2], `CH_COMMA};
		expq = {expq, blk};
		for (int i = 1; i < expq.size(); i++) cs ^= expq[i];
		expq = {expq, `CH_STAR, hexc(cs[7:4], 1'b0), hexc(cs[3:0], 1'b0), `CH_CR, `CH_LF};
		txq.delete();
		@(negedge i_sys_clk);
		i_glonass <= gl;
		i_sentence_type_code <= {typ[0], typ[1], typ[2]};
		i_send <= 1'b1;
		@(negedge i_sys_clk);
		i_send <= 1'b0;
		for (n = 0; n < 4000 && !(txq.size() >= expq.size() && o_load_ready === 1'b1); n++) @(negedge i_sys_clk);
		if (n == 4000) begin
			err_total++;
			close_out();
		end
		chk("tx_len", txq.size(), expq.size());
		foreach (expq[i]) chk("tx_byte", txq[i], expq[i]);
	endtask

	// feed one sentence, then check results against the parsed reference
	task automatic rx_case(input string pre, input string s, input logic low, input logic bad, input int ed, input int ee);
		char_t q[$];
		char_t cs;
		int idx;
		cs = 8'h00;
		idx = 0;
		rexp.delete();
		rxq.delete();
		for (int i = 0; i < pre.len(); i++) q.push_back(pre[i]);
		q.push_back(`CH_DOLLAR);
		for (int i = 0; i < s.len(); i++) begin
			q.push_back(s[i]);
			cs ^= s[i];
			if (i >= 5) begin
				if (s[i] == ",") idx++;
				else rexp.push_back({idx[6:0], s[i]});
			end
		end
		if (bad) cs = ~cs;
		q = {q, `CH_STAR, hexc(cs[7:4], low), hexc(cs[3:0], low), `CH_CR, `CH_LF};
		done_cnt = 0;
		rerr_cnt = 0;
		char_engine_model_i.feed(q);
		repeat (6) @(negedge i_sys_clk);
		chk("rx_done", done_cnt, ed);
		chk("rx_err", rerr_cnt, ee);
		if (ed == 1) begin
			chk("rx_fields", rxq.size(), rexp.size());
			foreach (rexp[i]) chk("rx_field", rxq[i], rexp[i]);
			chk("rx_hdr", o_rx_hdr, {s[0], s[1], s[2], s[3], s[4]});
		end
	endtask

	initial begin
		field_class_t tc[14];
		char_t td[14];
		char_t hx;
		int n;
		tc = '{FC_STATUS, FC_STATUS, FC_DIGIT, FC_DIGIT, FC_NUMERIC, FC_NUMERIC, FC_HEX, FC_HEX,
			FC_ALPHA, FC_ALPHA, FC_FREE, FC_FREE, FC_STATUS, FC_ALPHA};
		td = '{"A", "B", "7", "-", "-", "x", "F", "G", "q", "3", ",", "*", "V", "Q"};
		void'($urandom(32'hf7e525ee));
		repeat (8) @(negedge i_sys_clk);
		chk("rst_ready", o_load_ready, 1'b1);
		chk("rst_valid", o_tx_valid, 1'b0);
		i_reset <= 1'b0;
		stall_en <= 1'b1;
		// every class with one accepted and one refused character
		for (int i = 0; i < 14; i++) begin
			load_char(tc[i], td[i], i == 0, (i < 12) && i[0]);
			if (!((i < 12) && i[0])) blk.push_back(td[i]);
		end
		do_send(1'b0, "TST");
		// a full block, one more refused, then sent from both sources
		blk.delete();
		for (int i = 0; i < 70; i++) begin
			hx = hexc($urandom_range(15), 1'b0);
			load_char(FC_HEX, hx, i == 0, 1'b0);
			blk.push_back(hx);
		end
		load_char(FC_HEX, "A", 1'b0, 1'b1);
		do_send(1'b0, "LNG");
		do_send(1'b1, "LNG");
		// receive side cases
		rx_case("", "GPTST,A,12.5,,x", 1'b0, 1'b0, 1, 0);
		rx_case("", "GLTST,ab,,9F", 1'b1, 1'b0, 1, 0);
		rx_case("", "GPTST,A,1", 1'b0, 1'b1, 0, 1);
		rx_case("$GPTS", "GPTST,V,0", 1'b0, 1'b0, 1, 1);
		rx_case("", {"GPTST,", digits(70)}, 1'b0, 1'b0, 1, 0);
		rx_case("", {"GPTST,", digits(71)}, 1'b0, 1'b0, 0, 1);
		// tick spacing, then the second tick held off
		i_output_en <= 1'b1;
		for (n = 0; n < 1000 && !(sec_gap != 0 && baud_gap != 0); n++) @(negedge i_sys_clk);
		if (n == 1000) begin
			err_total++;
			close_out();
		end
		chk("sec_gap", sec_gap, SEC);
		chk("baud_gap", baud_gap, `BAUD_CYCLES);
		i_output_en <= 1'b0;
		repeat (3) @(negedge i_sys_clk);
		sec_cnt = 0;
		repeat (3 * SEC) @(negedge i_sys_clk);
		chk("sec_off", sec_cnt, 0);
		close_out();
	end
endmodule

`default_nettype wire
